// file: design/nsx_consts.svh
// Constants for the nibble swap, trap, exchange and xor execution block
`ifndef NSX_CONSTS_SVH
`define NSX_CONSTS_SVH
`define NSX_ESC_PREFIX     8'ha5
`define NSX_OP_SWAP        8'hc4
`define NSX_OP_TRAP        8'hb9
`define NSX_OP_XCH_DIR     8'hc5
`define NSX_OP_XCH_IND     7'h63
`define NSX_OP_XCH_REG     5'h19
`define NSX_OP_LOW_DIGIT_EXCHANGE_OP_IND    7'h6b
`define NSX_OP_XRL_DIR_A   8'h62
`define NSX_OP_XRL_DIR_IMM 8'h63
`define NSX_OP_XRL_A_IMM   8'h64
`define NSX_OP_XRL_A_DIR   8'h65
`define NSX_OP_XRL_A_IND   7'h33
`define NSX_OP_XRL_A_REG   5'h0d
`define NSX_OP_XRL_RR      8'h6c
`define NSX_OP_XRL_WW      8'h6d
`define NSX_OP_XRL_EXT     8'h6e
`define NSX_SUB_IMM8       4'h0
`define NSX_SUB_DIR8       4'h1
`define NSX_SUB_DIR16      4'h3
`define NSX_SUB_IMM16      4'h4
`define NSX_SUB_WDIR8      4'h5
`define NSX_SUB_WDIR16     4'h7
`define NSX_SUB_IND_W      4'h9
`define NSX_SUB_IND_D      4'hb
`define NSX_TRAP_VECTOR    24'hff007b
`define NSX_SP_STEP        16'h0002
`define NSX_SP_RESET       16'h0007
`define NSX_Z_BIT          1
`endif

// file: design/nsx_pkg.sv
// Types for the nibble swap, trap, exchange and xor execution block
package nsx_pkg;
  typedef enum logic [1:0] {NSX_IDLE, NSX_PRE, NSX_BUSY} nsx_phase_t;
  typedef enum logic [3:0] {
    NSX_K_NONE, NSX_K_SWAP, NSX_K_TRAP, NSX_K_XCH, NSX_K_LOW_DIGIT_EXCHANGE_OP, NSX_K_XRL_B,
    NSX_K_XRL_W, NSX_K_XRL_DIR, NSX_K_ILLEGAL
  } nsx_kind_t;
  typedef enum logic [2:0] {
    NSX_S_REG, NSX_S_DIR, NSX_S_IND, NSX_S_IMM, NSX_S_ACC
  } nsx_src_t;
  typedef struct packed {
    logic        valid;
    logic [7:0]  opcode;
    logic [7:0]  ext;
    logic [15:0] imm;
    logic [15:0] addr;
  } nsx_instr_t;
  typedef struct packed {
    logic [7:0]  acc;
    logic [15:0] sp;
    logic [23:0] pc;
    logic        zero;
  } nsx_arch_t;
  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [15:0] data;
    logic        word;
  } nsx_wr_t;
  typedef struct packed {
    nsx_phase_t  phase;
    logic        prefixed;
    nsx_arch_t   arch;
    nsx_wr_t     wr;
    logic        mem_we;
    logic [15:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic        push;
    logic [15:0] push_addr;
    logic [23:0] push_pc;
    logic        irq_block;
    logic        done;
    logic        illegal;
  } nsx_state_t;
endpackage

// file: design/nsx_exec.sv
// Execution unit for nibble swap, trap, exchange and xor instructions
`timescale 1ns/1ps
`include "nsx_consts.svh"
module nsx_exec #(
  parameter int ADDR_W = 16
) (
  input  wire logic               CORE_CLK,
  input  wire logic               RST,
  input  wire logic               SOURCE_MODE,
  input  wire nsx_pkg::nsx_instr_t INSTR,
  input  wire logic [7:0]         REG_BYTE,
  input  wire logic [15:0]        REG_WORD,
  input  wire logic [7:0]         SRC_REG_BYTE,
  input  wire logic [15:0]        SRC_REG_WORD,
  input  wire logic [7:0]         PTR_BYTE,
  input  wire logic [7:0]         MEM_DATA,
  input  wire logic [15:0]        MEM_WORD,
  input  wire logic               DIR_IS_PORT,
  input  wire logic [7:0]         PORT_LATCH,
  input  wire logic               IRQ_ENABLE,
  output logic [7:0]              ACC,
  output logic [15:0]             SP,
  output logic [23:0]             PC,
  output logic                    ZERO_FLAG,
  output nsx_pkg::nsx_wr_t        REG_WR,
  output logic                    MEM_WE,
  output logic [15:0]             MEM_ADDR,
  output logic [7:0]              MEM_WDATA,
  output logic                    PUSH_WE,
  output logic [15:0]             PUSH_ADDR,
  output logic [23:0]             PUSH_PC,
  output logic                    IRQ_BLOCK,
  output logic                    DONE,
  output logic                    ILLEGAL
);
  // Refuse address widths the pointer and register paths cannot serve
  if (ADDR_W != 16) begin : g_addr_w_check
    $error("nsx_exec serves only a 16-bit data address");
  end

  nsx_pkg::nsx_state_t st;
  nsx_pkg::nsx_state_t next_st;

  // Form the on-chip RAM address held in a pointer register
  function automatic logic [15:0] ind_addr(input logic [7:0] ptr);
    begin
      ind_addr = {8'h00, ptr};
    end
  endfunction

  // Exchange with a bank register rather than a memory byte
  function automatic logic xch_reg_form(input logic [7:0] op);
    begin
      xch_reg_form = (op[7:3] == `NSX_OP_XCH_REG);
    end
  endfunction

  // Legacy accumulator xor with a bank register
  function automatic logic acc_reg_form(input logic [7:0] op);
    begin
      acc_reg_form = (op[7:3] == `NSX_OP_XRL_A_REG);
    end
  endfunction

  // Sub-mode nibbles that the extended xor knows
  function automatic logic sub_ok(input logic [3:0] sub);
    begin
      unique case (sub)
        `NSX_SUB_IMM8,
        `NSX_SUB_DIR8,
        `NSX_SUB_DIR16,
        `NSX_SUB_IMM16,
        `NSX_SUB_WDIR8,
        `NSX_SUB_WDIR16,
        `NSX_SUB_IND_W,
        `NSX_SUB_IND_D: sub_ok = 1'b1;
        default:        sub_ok = 1'b0;
      endcase
    end
  endfunction

  // Tell whether an extended xor writes a whole word register
  function automatic logic word_form(input nsx_pkg::nsx_instr_t ins);
    begin
      word_form = 1'b0;
      if (ins.opcode == `NSX_OP_XRL_WW) begin
        word_form = 1'b1;
      end else if (ins.opcode == `NSX_OP_XRL_EXT) begin
        unique case (ins.ext[3:0])
          `NSX_SUB_IMM16,
          `NSX_SUB_WDIR8,
          `NSX_SUB_WDIR16: word_form = 1'b1;
          default:         word_form = 1'b0;
        endcase
      end
    end
  endfunction

  // Pick the word source operand of an extended word xor
  function automatic logic [15:0] word_src(input nsx_pkg::nsx_instr_t ins,
                                           input logic [15:0] srw,
                                           input logic [15:0] mem);
    begin
      word_src = mem;
      if (ins.opcode == `NSX_OP_XRL_WW) begin
        word_src = srw;
      end else if (ins.ext[3:0] == `NSX_SUB_IMM16) begin
        word_src = ins.imm;
      end
    end
  endfunction

  // Classify an opcode, taking the prefix and operating mode into account
  function automatic nsx_pkg::nsx_kind_t classify(input logic [7:0] op,
                                                  input logic [3:0] sub,
                                                  input logic pre,
                                                  input logic src_mode);
    logic legacy_ok;
    logic ext_ok;
    begin
      // legacy needs A5 in source mode
      legacy_ok = src_mode ? pre : !pre;
      // extended needs A5 in binary mode
      ext_ok = src_mode ? !pre : pre;
      classify = nsx_pkg::NSX_K_ILLEGAL;
      if (op == `NSX_OP_SWAP && !pre) begin
        classify = nsx_pkg::NSX_K_SWAP;
      end else if (op == `NSX_OP_TRAP && ext_ok) begin
        classify = nsx_pkg::NSX_K_TRAP;
      end else if (op == `NSX_OP_XCH_DIR && !pre) begin
        classify = nsx_pkg::NSX_K_XCH;
      end else if ((op[7:1] == `NSX_OP_XCH_IND || xch_reg_form(op)) && legacy_ok) begin
        classify = nsx_pkg::NSX_K_XCH;
      end else if (op[7:1] == `NSX_OP_LOW_DIGIT_EXCHANGE_OP_IND && legacy_ok) begin
        classify = nsx_pkg::NSX_K_LOW_DIGIT_EXCHANGE_OP;
      end else if ((op == `NSX_OP_XRL_DIR_A || op == `NSX_OP_XRL_DIR_IMM) && !pre) begin
        classify = nsx_pkg::NSX_K_XRL_DIR;
      end else if ((op == `NSX_OP_XRL_A_IMM || op == `NSX_OP_XRL_A_DIR) && !pre) begin
        classify = nsx_pkg::NSX_K_XRL_B;
      end else if ((op[7:1] == `NSX_OP_XRL_A_IND || acc_reg_form(op)) && legacy_ok) begin
        classify = nsx_pkg::NSX_K_XRL_B;
      end else if ((op == `NSX_OP_XRL_RR || op == `NSX_OP_XRL_WW
                    || (op == `NSX_OP_XRL_EXT && sub_ok(sub))) && ext_ok) begin
        classify = nsx_pkg::NSX_K_XRL_W;
      end
    end
  endfunction

  // Pick the byte source operand of an accumulator or register xor
  function automatic logic [7:0] byte_src(input nsx_pkg::nsx_instr_t ins,
                                          input logic wide,
                                          input logic [7:0] rb,
                                          input logic [7:0] srb,
                                          input logic [7:0] mem);
    begin
      // Extended forms reuse opcodes of the legacy register forms
      byte_src = mem;
      if (wide) begin
        if (ins.opcode == `NSX_OP_XRL_RR) begin
          byte_src = srb;
        end else if (ins.ext[3:0] == `NSX_SUB_IMM8) begin
          byte_src = ins.imm[7:0];
        end
      end else if (ins.opcode == `NSX_OP_XRL_A_IMM) begin
        byte_src = ins.imm[7:0];
      end else if (acc_reg_form(ins.opcode)) begin
        byte_src = rb;
      end
    end
  endfunction

  always_comb begin
    nsx_pkg::nsx_kind_t kind;
    logic [7:0]  res8;
    logic [15:0] res16;
    logic [7:0]  orig;
    logic [7:0]  mask;
    logic        acc_dest;
    kind = classify(INSTR.opcode, INSTR.ext[3:0], st.prefixed, SOURCE_MODE);
    res8 = 8'h00;
    res16 = 16'h0000;
    orig = 8'h00;
    mask = 8'h00;
    acc_dest = 1'b0;
    next_st = st;
    next_st.wr.we = 1'b0;
    next_st.push = 1'b0;
    next_st.done = 1'b0;
    next_st.illegal = 1'b0;
    next_st.mem_we = 1'b0;
    unique case (st.phase)
      nsx_pkg::NSX_IDLE,
      nsx_pkg::NSX_PRE: begin
        if (INSTR.valid && INSTR.opcode == `NSX_ESC_PREFIX && st.phase == nsx_pkg::NSX_IDLE) begin
          next_st.phase = nsx_pkg::NSX_PRE;
          next_st.prefixed = 1'b1;
        end else if (INSTR.valid) begin
          next_st.phase = nsx_pkg::NSX_BUSY;
          next_st.done = 1'b1;
          next_st.irq_block = (kind == nsx_pkg::NSX_K_TRAP);
          unique case (kind)
            nsx_pkg::NSX_K_SWAP: begin
              next_st.arch.acc = {st.arch.acc[3:0], st.arch.acc[7:4]};
            end
            nsx_pkg::NSX_K_TRAP: begin
              next_st.arch.sp = st.arch.sp - `NSX_SP_STEP;
              next_st.push = 1'b1;
              next_st.push_addr = st.arch.sp - `NSX_SP_STEP;
              next_st.push_pc = st.arch.pc;
              next_st.arch.pc = `NSX_TRAP_VECTOR;
            end
            nsx_pkg::NSX_K_XCH: begin
              if (xch_reg_form(INSTR.opcode)) begin
                next_st.arch.acc = REG_BYTE;
                next_st.wr.we = 1'b1;
                next_st.wr.word = 1'b0;
                next_st.wr.addr = {13'h0000, INSTR.opcode[2:0]};
                next_st.wr.data = {8'h00, st.arch.acc};
              end else begin
                next_st.arch.acc = MEM_DATA;
                next_st.mem_we = 1'b1;
                next_st.mem_addr = (INSTR.opcode == `NSX_OP_XCH_DIR) ? INSTR.addr
                                                                     : ind_addr(PTR_BYTE);
                next_st.mem_wdata = st.arch.acc;
              end
            end
            nsx_pkg::NSX_K_LOW_DIGIT_EXCHANGE_OP: begin
              next_st.arch.acc = {st.arch.acc[7:4], MEM_DATA[3:0]};
              next_st.mem_we = 1'b1;
              next_st.mem_addr = ind_addr(PTR_BYTE);
              next_st.mem_wdata = {MEM_DATA[7:4], st.arch.acc[3:0]};
            end
            nsx_pkg::NSX_K_XRL_B: begin
              res8 = st.arch.acc ^ byte_src(INSTR, 1'b0, REG_BYTE, SRC_REG_BYTE, MEM_DATA);
              next_st.arch.acc = res8;
              next_st.arch.zero = (res8 == 8'h00);
            end
            nsx_pkg::NSX_K_XRL_W: begin
              next_st.wr.we = 1'b1;
              next_st.wr.addr = {12'h000, INSTR.ext[7:4]};
              next_st.wr.word = word_form(INSTR);
              if (next_st.wr.word) begin
                res16 = REG_WORD ^ word_src(INSTR, SRC_REG_WORD, MEM_WORD);
              end else begin
                res16 = {8'h00, REG_BYTE ^ byte_src(INSTR, 1'b1, REG_BYTE, SRC_REG_BYTE,
                                                    MEM_DATA)};
              end
              next_st.wr.data = res16;
              next_st.arch.zero = (res16 == 16'h0000);
            end
            nsx_pkg::NSX_K_XRL_DIR: begin
              acc_dest = (INSTR.opcode == `NSX_OP_XRL_DIR_A);
              mask = acc_dest ? st.arch.acc : INSTR.imm[7:0];
              orig = DIR_IS_PORT ? PORT_LATCH : MEM_DATA;
              res8 = orig ^ mask;
              next_st.mem_we = 1'b1;
              next_st.mem_addr = INSTR.addr;
              next_st.mem_wdata = res8;
              next_st.arch.zero = (res8 == 8'h00);
            end
            default: begin
              // Refused combination: no completion, no state change
              next_st.done = 1'b0;
              next_st.illegal = 1'b1;
              next_st.irq_block = 1'b0;
            end
          endcase
        end
      end
      nsx_pkg::NSX_BUSY: begin
        next_st.phase = nsx_pkg::NSX_IDLE;
        next_st.prefixed = 1'b0;
      end
      default: begin
        next_st.phase = nsx_pkg::NSX_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      st <= '0;
      st.phase <= nsx_pkg::NSX_IDLE;
      st.arch.sp <= `NSX_SP_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign ACC       = st.arch.acc;
  assign SP        = st.arch.sp;
  assign PC        = st.arch.pc;
  assign ZERO_FLAG = st.arch.zero;
  assign REG_WR    = st.wr;
  assign MEM_WE    = st.mem_we;
  assign MEM_ADDR  = st.mem_addr;
  assign MEM_WDATA = st.mem_wdata;
  assign PUSH_WE   = st.push;
  assign PUSH_ADDR = st.push_addr;
  assign PUSH_PC   = st.push_pc;
  assign IRQ_BLOCK = st.irq_block;
  assign DONE      = st.done;
  assign ILLEGAL   = st.illegal;
endmodule

// file: test/nsx_exec_asserts.sv
// Assertions for the nsx execution unit
`timescale 1ns/1ps
module nsx_exec_asserts (
  input wire logic                CORE_CLK,
  input wire logic                RST,
  input wire nsx_pkg::nsx_instr_t INSTR,
  input wire logic [7:0]          MEM_DATA,
  input wire logic                DIR_IS_PORT,
  input wire logic [7:0]          PORT_LATCH,
  input wire logic [7:0]          ACC,
  input wire logic [15:0]         SP,
  input wire logic [23:0]         PC,
  input wire logic                ZERO_FLAG,
  input wire logic                MEM_WE,
  input wire logic [15:0]         MEM_ADDR,
  input wire logic [7:0]          MEM_WDATA,
  input wire logic                PUSH_WE,
  input wire logic [15:0]         PUSH_ADDR,
  input wire logic [23:0]         PUSH_PC,
  input wire logic                IRQ_BLOCK,
  input wire logic                DONE,
  input wire logic                ILLEGAL
);
  logic [7:0] op;
  assign op = INSTR.opcode;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  chk_swap_rot: assert property (
    DONE && $past(op) == 8'hc4 |-> ACC == {$past(ACC[3:0]), $past(ACC[7:4])})
    else $error("swap result wrong");
  chk_trap_jump: assert property (
    DONE && $past(op) == 8'hb9 |-> PC == 24'hff007b && IRQ_BLOCK)
    else $error("trap target or block wrong");
  chk_trap_push: assert property (
    DONE && $past(op) == 8'hb9 |-> PUSH_WE && SP == $past(SP) - 16'h0002
      && PUSH_ADDR == SP && PUSH_PC == $past(PC))
    else $error("trap push wrong");
  chk_push_cause: assert property (
    PUSH_WE |-> DONE && $past(op) == 8'hb9)
    else $error("push without trap");
  chk_xch_dir: assert property (
    DONE && $past(op) == 8'hc5 |-> MEM_WE && MEM_ADDR == $past(INSTR.addr)
      && MEM_WDATA == $past(ACC) && ACC == $past(MEM_DATA))
    else $error("exchange wrong");
  chk_digit_swap: assert property (
    DONE && $past(op[7:1]) == 7'h6b |-> MEM_WDATA == {$past(MEM_DATA[7:4]), $past(ACC[3:0])}
      && ACC == {$past(ACC[7:4]), $past(MEM_DATA[3:0])})
    else $error("digit exchange wrong");
  chk_port_latch: assert property (
    DONE && $past(op) == 8'h62 && $past(DIR_IS_PORT) |->
      MEM_WDATA == ($past(PORT_LATCH) ^ $past(ACC)))
    else $error("port xor ignored latch");
  chk_illegal_quiet: assert property (
    ILLEGAL |-> !DONE && !MEM_WE && !PUSH_WE && $stable(ACC) && $stable(SP))
    else $error("refused opcode changed state");
  chk_flag_kept: assert property (
    DONE && $past(op) inside {8'hc4, 8'hb9, 8'hc5} |-> $stable(ZERO_FLAG))
    else $error("flag changed");
endmodule

bind nsx_exec nsx_exec_asserts u_chk (
  .CORE_CLK(CORE_CLK), .RST(RST), .INSTR(INSTR), .MEM_DATA(MEM_DATA),
  .DIR_IS_PORT(DIR_IS_PORT), .PORT_LATCH(PORT_LATCH), .ACC(ACC), .SP(SP), .PC(PC),
  .ZERO_FLAG(ZERO_FLAG), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
  .PUSH_WE(PUSH_WE), .PUSH_ADDR(PUSH_ADDR), .PUSH_PC(PUSH_PC), .IRQ_BLOCK(IRQ_BLOCK),
  .DONE(DONE), .ILLEGAL(ILLEGAL));

// file: test/nibble_swap_exchange_xor_trap_exec_tb.sv
// Self-checking bench for the nsx execution unit
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module nibble_swap_exchange_xor_trap_exec_tb;
  logic                clk, rst, sm, dport, irq_en;
  nsx_pkg::nsx_instr_t instr;
  nsx_pkg::nsx_wr_t    reg_wr;
  logic [7:0]          reg_b, sreg_b, ptr, mem_b, latch, acc, mem_wdata;
  logic [15:0]         reg_w, sreg_w, mem_w, sp, mem_addr, push_addr;
  logic [23:0]         pc, push_pc;
  logic                zero, mem_we, push_we, irq_blk, done, illegal;
  int                  failures, checked, m_acc, m_sp, m_pc, m_zero;
  int                  ops[$] = '{'hc4, 'hb9, 'hc5, 'hc6, 'hc7, 'hcb, 'hd6, 'hd7,
                                  'h62, 'h63, 'h64, 'h65, 'h66, 'h67, 'h6a, 'h6c};

  nsx_exec DUT (.CORE_CLK(clk), .RST(rst), .SOURCE_MODE(sm), .INSTR(instr),
    .REG_BYTE(reg_b), .REG_WORD(reg_w), .SRC_REG_BYTE(sreg_b), .SRC_REG_WORD(sreg_w),
    .PTR_BYTE(ptr), .MEM_DATA(mem_b), .MEM_WORD(mem_w), .DIR_IS_PORT(dport),
    .PORT_LATCH(latch), .IRQ_ENABLE(irq_en), .ACC(acc), .SP(sp), .PC(pc),
    .ZERO_FLAG(zero), .REG_WR(reg_wr), .MEM_WE(mem_we), .MEM_ADDR(mem_addr),
    .MEM_WDATA(mem_wdata), .PUSH_WE(push_we), .PUSH_ADDR(push_addr), .PUSH_PC(push_pc),
    .IRQ_BLOCK(irq_blk), .DONE(done), .ILLEGAL(illegal));

  function automatic bit need_pre(input int op);
    if (op == 'hb9 || op == 'h6c) return !sm;
    return sm && (op inside {['hc6:'hcf], ['hd6:'hd7], ['h66:'h6f]});
  endfunction

  task automatic cmp_state;
    `CHK(acc, 8'(m_acc))
    `CHK(sp, 16'(m_sp))
    `CHK(pc, 24'(m_pc))
    `CHK(zero, 1'(m_zero))
  endtask

  task automatic reset_dut;
    rst = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    m_acc = 0;
    m_sp = 7;
    m_pc = 0;
    m_zero = 0;
    cmp_state();
  endtask

  task automatic run(input int op, input bit drop);
    int a, pc0, mw, wd, ma, rwe, rd, orig, ra;
    @(negedge clk);
    instr.imm = 16'($urandom);
    instr.addr = 16'($urandom);
    instr.ext = 8'($urandom);
    {reg_b, sreg_b, ptr, mem_b} = $urandom;
    {reg_w, sreg_w} = $urandom;
    {latch, mem_w} = 24'($urandom);
    irq_en = 1'($urandom);
    dport = (op == 'h62 || op == 'h63) ? 1'($urandom) : 1'b0;
    if (op == 'h64 && $urandom % 2) instr.imm[7:0] = 8'(m_acc);
    if (need_pre(op) && !drop) begin
      instr.valid = 1'b1;
      instr.opcode = 8'ha5;
      @(negedge clk);
    end
    instr.valid = 1'b1;
    instr.opcode = 8'(op);
    a = m_acc;
    pc0 = m_pc;
    {mw, wd, rwe, rd, ra} = 0;
    ma = instr.addr;
    orig = dport ? latch : mem_b;
    if (!drop) case (op) inside
      'hc4: m_acc = {a[3:0], a[7:4]};
      'hb9: begin m_sp = m_sp - 2; m_pc = 'hff007b; end
      'hc5, 'hc6, 'hc7: begin m_acc = mem_b; mw = 1; wd = a; if (op != 'hc5) ma = ptr; end
      ['hc8:'hcf]: begin m_acc = reg_b; rwe = 1; rd = a; ra = op & 7; end
      'hd6, 'hd7: begin m_acc = {a[7:4], mem_b[3:0]}; mw = 1; wd = {mem_b[7:4], a[3:0]};
        ma = ptr; end
      'h62, 'h63: begin wd = orig ^ (op == 'h62 ? a : instr.imm[7:0]); mw = 1;
        m_zero = wd == 0; end
      'h6c: begin rwe = 1; rd = reg_b ^ sreg_b; ra = instr.ext[7:4]; m_zero = rd == 0; end
      ['h64:'h6f]: begin m_acc = a ^ (op == 'h64 ? instr.imm[7:0] : op < 'h68 ? mem_b : reg_b);
        m_zero = m_acc == 0; end
    endcase
    @(negedge clk);
    instr.valid = 1'b0;
    `CHK(done, !drop)
    `CHK(illegal, drop)
    cmp_state();
    `CHK(mem_we, 1'(mw))
    if (mw) `CHK(mem_addr, 16'(ma))
    if (mw) `CHK(mem_wdata, 8'(wd))
    `CHK(reg_wr.we, 1'(rwe))
    if (rwe) `CHK(reg_wr.data, 16'(rd))
    if (rwe) `CHK({reg_wr.word, reg_wr.addr}, {1'b0, 16'(ra)})
    `CHK(push_we, 1'(op == 'hb9 && !drop))
    if (op == 'hb9 && !drop) `CHK({push_addr, push_pc}, {16'(m_sp), 24'(pc0)})
    `CHK(irq_blk, 1'(op == 'hb9 && !drop))
    @(negedge clk);
  endtask

  task automatic summarize;
    if (failures == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #200000;
    failures++;
    summarize();
  end

  initial begin
    {rst, sm, dport, irq_en, instr, reg_b, sreg_b, ptr, mem_b, latch} = '0;
    {reg_w, sreg_w, mem_w, failures, checked} = '0;
    void'($urandom(41588));
    reset_dut();
    for (int m = 0; m < 2; m++) begin
      sm = m[0];
      for (int r = 0; r < 4; r++) foreach (ops[i]) run(ops[i], 1'b0);
      foreach (ops[i]) if (need_pre(ops[i]) && ops[i] != 'h6c) run(ops[i], 1'b1);
    end
    reset_dut();
    foreach (ops[i]) run(ops[i], 1'b0);
    summarize();
  end
endmodule
